// ### include/qdc_params.svh
// constants shared by both ends of the quad converter serial load link
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH
`define QDC_CORE_MHZ        100
`define QDC_WORD_BITS       16
`define QDC_DATA_BITS       12
`define QDC_ADDR_HI_POS     15
`define QDC_ADDR_LO_POS     14
`define QDC_DATA_MSB_POS    11
`define QDC_CLEAR_MID       12'h800
`define QDC_CLEAR_ZERO      12'h000
`define QDC_FIFO_DEPTH      16
`define QDC_HALF_DIV        6
`define QDC_T_LD1_NS        40
`define QDC_T_LDW_NS        45
`define QDC_T_CLRW_NS       70
`define QDC_LD1_CYC         ((`QDC_T_LD1_NS * `QDC_CORE_MHZ + 999) / 1000)
`define QDC_LDW_CYC         ((`QDC_T_LDW_NS * `QDC_CORE_MHZ + 999) / 1000)
`define QDC_CLRW_CYC        ((`QDC_T_CLRW_NS * `QDC_CORE_MHZ + 999) / 1000)
`endif

// ### include/qdc_pkg.sv
// types for the quad converter serial load link
`default_nettype none
package qdc_pkg;
   typedef enum logic [2:0] {
      QDC_IDLE    = 3'b000,
      QDC_SHIFT   = 3'b001,
      QDC_DESEL   = 3'b010,
      QDC_LD_WAIT = 3'b011,
      QDC_LOAD    = 3'b100,
      QDC_GAP     = 3'b101,
      QDC_CLEAR   = 3'b110
   } qdc_host_state_type;
   typedef logic [11:0] qdc_value_type;
endpackage : qdc_pkg
`default_nettype wire

// ### include/qdc_if.sv
// serial load link between host controller and quad converter front end
`timescale 1ns/10ps
`default_nettype none
interface qdc_if;
   logic sclk;
   logic select_n;
   logic serial_in;
   logic load_strobe_n;
   logic clear_n;
   logic clear_value_select;
   modport host (output sclk, output select_n, output serial_in, output load_strobe_n,
                 output clear_n, output clear_value_select);
   modport dev  (input sclk, input select_n, input serial_in, input load_strobe_n,
                 input clear_n, input clear_value_select);
endinterface : qdc_if
`default_nettype wire

// ### hdl/qdc_dev.sv
// converter end: serial shift register, addressed load and asynchronous clear
`timescale 1ns/10ps
`default_nettype none
`include "qdc_params.svh"
module qdc_dev (
   qdc_if.dev                  link,
   output logic [3:0][11:0]    dac_value
);
   logic [`QDC_WORD_BITS-1:0] shreg;
   logic                      clear_mid;
   logic                      mid_now;
   // one flag per channel, kept unpacked so each channel process owns its own element
   logic                      held [4];
   qdc_pkg::qdc_value_type    data [4];
   wire                       shift_clk = link.sclk | link.select_n;

   // a deselected link holds shift_clk high, so no edge reaches the register
   always_ff @(posedge shift_clk) begin
      shreg <= {shreg[`QDC_WORD_BITS-2:0], link.serial_in};
   end

   // clear value follows the select pin while clear is low, latched when it ends
   always_ff @(posedge link.clear_n) begin
      clear_mid <= link.clear_value_select;
   end
   assign mid_now = link.clear_n ? clear_mid : link.clear_value_select;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         // clear only touches the channel flags, never shreg
         always_ff @(negedge link.load_strobe_n or negedge link.clear_n) begin
            if (!link.clear_n)
               held[g] <= 1'b1;
            else if (shreg[`QDC_ADDR_HI_POS:`QDC_ADDR_LO_POS] == 2'(g))
               held[g] <= 1'b0;
         end
         always_ff @(negedge link.load_strobe_n) begin
            if (shreg[`QDC_ADDR_HI_POS:`QDC_ADDR_LO_POS] == 2'(g))
               data[g] <= shreg[`QDC_DATA_MSB_POS:0];
         end
         assign dac_value[g] = held[g] ? (mid_now ? `QDC_CLEAR_MID : `QDC_CLEAR_ZERO)
                                       : data[g];
      end
   endgenerate
endmodule : qdc_dev
`default_nettype wire

// ### hdl/qdc_host.sv
// host end: word fifo and serial link sequencer with derived link clock
`timescale 1ns/10ps
`default_nettype none
`include "qdc_params.svh"
module qdc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = `QDC_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : qdc_fifo

module qdc_host #(
   parameter int HALF_DIV = `QDC_HALF_DIV
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [1:0]  wr_addr,
   input  wire logic [11:0] wr_data,
   input  wire logic        clear_req,
   input  wire logic        clear_mode,
   output logic             busy,
   qdc_if.host              link
);
   if (HALF_DIV < 1 || HALF_DIV > 255) begin : g_bad
      $error("HALF_DIV out of range 1..255");
   end
   localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);
   localparam logic [7:0] LD1_LAST  = 8'(`QDC_LD1_CYC - 1);
   localparam logic [7:0] LDW_LAST  = 8'(`QDC_LDW_CYC - 1);
   localparam logic [7:0] CLRW_LAST = 8'(`QDC_CLRW_CYC - 1);

   qdc_pkg::qdc_host_state_type state;
   logic        f_valid;
   logic        f_ready;
   logic [13:0] f_data;
   logic [15:0] word;
   logic [7:0]  cnt;
   logic [3:0]  bitcnt;
   logic        clear_pend;
   logic        clear_take;

   qdc_fifo #(.WIDTH(14), .DEPTH(`QDC_FIFO_DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   ({wr_addr, wr_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // clear has priority over a queued word; the fifo stalls until the link is idle
   assign clear_take = (state == qdc_pkg::QDC_IDLE) && clear_pend;
   assign f_ready    = (state == qdc_pkg::QDC_IDLE) && !clear_pend;
   assign busy       = (state != qdc_pkg::QDC_IDLE) || clear_pend || f_valid;

   // a request arriving with the take still wins
   always_ff @(posedge core_clk) begin
      if (rst)
         clear_pend <= 1'b0;
      else
         clear_pend <= (clear_pend & ~clear_take) | clear_req;
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         link.clear_value_select <= 1'b0;
      else
         link.clear_value_select <= clear_mode;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state              <= qdc_pkg::QDC_IDLE;
         link.sclk          <= 1'b1;
         link.select_n      <= 1'b1;
         link.serial_in     <= 1'b0;
         link.load_strobe_n <= 1'b1;
         link.clear_n       <= 1'b1;
         word               <= '0;
         cnt                <= '0;
         bitcnt             <= '0;
      end else begin
         case (state)
            qdc_pkg::QDC_IDLE: begin
               cnt <= '0;
               if (clear_take) begin
                  link.clear_n <= 1'b0;
                  state        <= qdc_pkg::QDC_CLEAR;
               end else if (f_valid) begin
                  // address, two fill bits, data
                  word          <= {f_data[13:12], 2'b00, f_data[11:0]};
                  bitcnt        <= '0;
                  link.select_n <= 1'b0;
                  state         <= qdc_pkg::QDC_SHIFT;
               end
            end
            qdc_pkg::QDC_SHIFT: begin
               if (cnt != HALF_LAST) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt <= '0;
                  if (link.sclk) begin
                     link.sclk      <= 1'b0;
                     link.serial_in <= word[15];
                     word           <= {word[14:0], 1'b0};
                  end else begin
                     link.sclk <= 1'b1;
                     bitcnt    <= bitcnt + 4'h1;
                     if (bitcnt == 4'hf)
                        state <= qdc_pkg::QDC_DESEL;
                  end
               end
            end
            qdc_pkg::QDC_DESEL: begin
               if (cnt != HALF_LAST) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt           <= '0;
                  link.select_n <= 1'b1;
                  state         <= qdc_pkg::QDC_LD_WAIT;
               end
            end
            qdc_pkg::QDC_LD_WAIT: begin
               if (cnt != LD1_LAST) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt                <= '0;
                  link.load_strobe_n <= 1'b0;
                  state              <= qdc_pkg::QDC_LOAD;
               end
            end
            qdc_pkg::QDC_LOAD: begin
               // link stays quiet with clock and select high while loading
               if (cnt != LDW_LAST) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt                <= '0;
                  link.load_strobe_n <= 1'b1;
                  state              <= qdc_pkg::QDC_GAP;
               end
            end
            qdc_pkg::QDC_GAP: begin
               if (cnt != HALF_LAST)
                  cnt <= cnt + 8'h01;
               else
                  state <= qdc_pkg::QDC_IDLE;
            end
            qdc_pkg::QDC_CLEAR: begin
               if (cnt != CLRW_LAST) begin
                  cnt <= cnt + 8'h01;
               end else begin
                  cnt          <= '0;
                  link.clear_n <= 1'b1;
                  state        <= qdc_pkg::QDC_GAP;
               end
            end
            default: begin
               state <= qdc_pkg::QDC_IDLE;
            end
         endcase
      end
   end
endmodule : qdc_host
`default_nettype wire

// ### bench/qdc_assertions.sv
// concurrent checks on the serial load link between host and converter
`timescale 1ns/10ps
`default_nettype none
module qdc_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic select_n,
   input wire logic serial_in,
   input wire logic load_strobe_n,
   input wire logic clear_n,
   input wire logic clear_value_select
);
   logic        sclk_q;
   logic [4:0]  rises;
   logic [15:0] word;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk) sclk_q <= sclk;
   always_ff @(posedge core_clk) begin
      if (rst || select_n) rises <= 5'h00;
      else if (sclk && !sclk_q) rises <= rises + 5'h01;
   end
   // bits as the converter sees them, taken at each link clock rise
   always_ff @(posedge core_clk) begin
      if (sclk && !sclk_q && !select_n) word <= {word[14:0], serial_in};
   end
   sequence load_pulse; !load_strobe_n [*5] ##1 load_strobe_n; endsequence
   sequence clear_pulse; !clear_n [*7] ##1 clear_n; endsequence
   a_word_length: assert property ($rose(select_n) |-> rises == 5'h10) else $error("frame length wrong");
   a_load_follows: assert property ($rose(select_n) |-> ##[1:8] $fell(load_strobe_n)) else $error("no load");
   a_fill_bits: assert property ($fell(load_strobe_n) |-> word[13:12] == 2'b00) else $error("fill bits");
   a_load_width: assert property ($fell(load_strobe_n) |-> load_pulse) else $error("load pulse");
   a_no_shift_load: assert property (!load_strobe_n |-> $stable(sclk) && $stable(select_n))
      else $error("shift edge during load");
   a_desel_high: assert property ($rose(select_n) |-> sclk && $past(sclk)) else $error("deselect low");
   a_clear_width: assert property ($fell(clear_n) |-> clear_pulse) else $error("clear pulse");
   a_clear_alone: assert property (!clear_n |-> select_n && load_strobe_n) else $error("clear overlap");
   a_idle_clock: assert property (select_n |-> sclk) else $error("clock low deselected");
   a_clear_value_select_steady: assert property (!clear_n |-> $stable(clear_value_select)) else $error("clear select moved");
endmodule : qdc_assertions
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench: host and converter ends joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "qdc_params.svh"
module testbench;
   `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error %0t: %h %h", $time, a, b); end end
   logic             core_clk = 1'b0;
   logic             rst = 1'b1;
   logic             wr_valid = 1'b0;
   logic             wr_ready;
   logic [1:0]       wr_addr = 2'h0;
   logic [11:0]      wr_data = 12'h000;
   logic             clear_req = 1'b0;
   logic             clear_mode = 1'b0;
   logic             busy;
   logic [3:0][11:0] dac_value;
   logic [3:0][11:0] mdl;
   logic [15:0]      cap;
   logic [15:0]      last_word = 16'h0000;
   logic [63:0]      exp_note;
   logic [63:0]      notes[$];
   logic             seen_full = 1'b0;
   int               err_total = 0;
   int               tests_run = 0;
   int               cyc = 0;
   qdc_if link_if ();
   qdc_host #(.HALF_DIV(3)) i_qdc_host (.core_clk(core_clk), .rst(rst), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data), .clear_req(clear_req), .clear_mode(clear_mode), .busy(busy), .link(link_if));
   qdc_dev i_qdc_dev (.link(link_if), .dac_value(dac_value));
   qdc_assertions i_chk (.core_clk(core_clk), .rst(rst), .sclk(link_if.sclk), .select_n(link_if.select_n),
      .serial_in(link_if.serial_in), .load_strobe_n(link_if.load_strobe_n), .clear_n(link_if.clear_n),
      .clear_value_select(link_if.clear_value_select));
   always #5 core_clk = ~core_clk;
   task end_sim;
      $display("TB: %0d errors in %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // caller holds wr_valid high across a burst so it is never set twice in one step
   task automatic send(input logic [1:0] a, input logic [11:0] d);
      wr_addr <= a;
      wr_data <= d;
      do @(posedge core_clk); while (wr_ready !== 1'b1);
      mdl[a] = d;
      last_word = {a, 2'b00, d};
      notes.push_back({last_word, mdl});
   endtask : send
   // only issued when idle, so the clear cannot jump ahead of queued words
   task automatic clr(input logic m);
      while (busy !== 1'b0) @(posedge core_clk);
      clear_mode <= m;
      @(posedge core_clk);
      clear_req <= 1'b1;
      @(posedge core_clk);
      clear_req <= 1'b0;
      @(posedge core_clk);
      `CHK(busy, 1'b1)
      mdl = {4{m ? `QDC_CLEAR_MID : `QDC_CLEAR_ZERO}};
      notes.push_back({last_word, mdl});
   endtask : clr
   always @(posedge link_if.sclk) begin
      if (link_if.select_n === 1'b0) cap <= {cap[14:0], link_if.serial_in};
   end
   always @(negedge link_if.load_strobe_n or posedge link_if.clear_n) begin
      #1;
      if (!rst) begin
         exp_note = notes.size() > 0 ? notes.pop_front() : 64'h0;
         `CHK(dac_value, exp_note[47:0])
         if (link_if.load_strobe_n === 1'b0) `CHK(cap, exp_note[63:48])
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (wr_ready === 1'b0) seen_full <= 1'b1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h8725));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         clr(p[0] ? 1'b0 : 1'b1);
         wr_valid <= 1'b1;
         for (int i = 0; i < (p == 1 ? 20 : 4); i++) send(p == 1 ? 2'($urandom) : i[1:0], 12'($urandom));
         wr_valid <= 1'b0;
      end
      while (busy !== 1'b0) @(posedge core_clk);
      `CHK(notes.size(), 0)
      `CHK(seen_full, 1'b1)
      end_sim();
   end
endmodule : testbench
`default_nettype wire
